// >>> dv/qbs_ctl.sv
// qbs_ctl: controller model driving the input side from a per-edge plan
// assumes: the bench fills the plan before the edge comes up
`timescale 1ns/100ps
`default_nettype none
module qbs_ctl
    import qbs_pkg::*;
(
    input  wire logic link_clk,
    input  wire logic nrst,
    output logic      read_sel_n,
    output logic      write_sel_n,
    output qbs_sa_t   shared_address,
    output qbs_data_t write_data_in,
    output logic      nibble_mask_low_n,
    output logic      nibble_mask_high_n,
    output logic      out_clk_c,
    output logic      out_clk_cn
);
    int        nxt = -2;     // index of the coming link edge
    int        i;
    bit        rd [1024];
    bit        wr [1024];
    bit        bt [1024];    // write beat due on this edge
    qbs_sa_t   ad [1024];
    qbs_data_t wd [1024];
    bit [1:0]  wm [1024];    // {high_n, low_n}
    logic      oc_run = 1'b0; // set by the bench before a reset
    logic      oc_ph  = 1'b0;
    // output clocks: held high for single mode, else a free-running
    // pair at the input-clock rate, moved on the falling link edge
    assign out_clk_c  = oc_run ? oc_ph : 1'b1;
    assign out_clk_cn = oc_run ? !oc_ph : 1'b1;
    // edge 0 is a true edge; a reset drops any plan left over
    always @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            nxt <= -2;
            rd  <= '{default: 1'b0};
            wr  <= '{default: 1'b0};
            bt  <= '{default: 1'b0};
        end else begin
            nxt <= nxt + 1;
        end
    end
    // released lines change every edge so no stale value can pass
    always @(negedge link_clk) begin
        i = (nxt < 0) ? 1023 : nxt;
        oc_ph <= !oc_ph;
        read_sel_n     <= !rd[i];
        write_sel_n    <= !wr[i];
        shared_address <= (rd[i] || wr[i]) ? ad[i] : ~shared_address;
        write_data_in  <= bt[i] ? wd[i] : ~write_data_in;
        {nibble_mask_high_n, nibble_mask_low_n} <= bt[i] ? wm[i]
            : ~{nibble_mask_high_n, nibble_mask_low_n};
    end
    // idle lines before the first edge
    initial begin
        read_sel_n = 1'b1;
        write_sel_n = 1'b1;
        shared_address = '0;
        write_data_in = '0;
        {nibble_mask_high_n, nibble_mask_low_n} = 2'h3;
    end
endmodule
`default_nettype wire

// >>> dv/qbs_sram_chk.sv
// qbs_chk: timing checks on the pins of qbs_sram
// assumes: link edge 0 is third edge after release; the echo step is
// checked only in single mode, with the output clocks tied high
`timescale 1ns/100ps
`default_nettype none
module qbs_chk
    import qbs_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic link_clk,
    input wire logic read_sel_n,
    input wire logic loop_off_n,
    input wire logic read_data_oe_n,
    input wire logic echo_clock_out,
    input wire logic echo_clock_out_n,
    input wire logic dll_enabled,
    input wire logic single_clock_mode,
    input wire logic read_port_idle
);
    logic [1:0] settle_q;
    logic       ph_q;
    logic [6:0] acc_q;
    logic       kedge;
    logic       rd_acc;
    // a read too soon after another never enters the history
    assign kedge  = (settle_q == 2'h2) || (settle_q == 2'h3 && ph_q);
    assign rd_acc = kedge && !read_sel_n && !acc_q[1];
    // edge phase and accepted-read history, reset like the link side
    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            settle_q <= 2'h0;
            ph_q     <= 1'b0;
            acc_q    <= '0;
        end else begin
            settle_q <= (settle_q == 2'h3) ? settle_q : settle_q + 2'h1;
            ph_q     <= (settle_q == 2'h3) ? !ph_q : ph_q;
            acc_q    <= {acc_q[5:0], rd_acc};
        end
    end
    read_window_a: assert property (@(posedge link_clk)
        disable iff (!nrst) read_data_oe_n == !(|acc_q[6:3]))
        else $error("read drivers on outside a burst");
    read_burst_a: assert property (@(posedge link_clk)
        disable iff (!nrst) rd_acc |-> ##4 (!read_data_oe_n) [*4])
        else $error("read burst shorter than four words");
    echo_pair_a: assert property (@(posedge link_clk)
        disable iff (!nrst) echo_clock_out != echo_clock_out_n)
        else $error("echo clocks not complementary");
    echo_run_a: assert property (@(posedge link_clk)
        disable iff (!nrst) (settle_q == 2'h3 && single_clock_mode)
        |-> echo_clock_out == !kedge) else $error("echo out of step");
    dll_on_a: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(loop_off_n) |-> ##[1:3] dll_enabled)
        else $error("loop not enabled");
    dll_off_a: assert property (@(posedge mclk) disable iff (!nrst)
        $fell(loop_off_n) |-> ##[1:3] !dll_enabled)
        else $error("loop not disabled");
    idle_status_a: assert property (@(posedge mclk) disable iff (!nrst)
        !read_data_oe_n |-> ##[0:3] !read_port_idle)
        else $error("idle shown while reading");
    mode_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
        single_clock_mode |=> single_clock_mode)
        else $error("clock mode changed");
    cover property (@(posedge link_clk) disable iff (!nrst) rd_acc);
    cover property (@(posedge link_clk) disable iff (!nrst) rd_acc ##4 rd_acc);
    cover property (@(posedge link_clk) kedge && !read_sel_n && acc_q[1]);
    cover property (@(posedge mclk) disable iff (!nrst)
        !single_clock_mode && !read_data_oe_n);
endmodule
bind qbs_sram qbs_chk i_chk (.mclk(mclk), .nrst(nrst), .link_clk(link_clk),
    .read_sel_n(read_sel_n), .loop_off_n(loop_off_n),
    .read_data_oe_n(read_data_oe_n), .echo_clock_out(echo_clock_out),
    .echo_clock_out_n(echo_clock_out_n), .dll_enabled(dll_enabled),
    .single_clock_mode(single_clock_mode), .read_port_idle(read_port_idle));
`default_nettype wire

// >>> dv/quad_rate_burst4_sram_port_bench.sv
// bench: bursts, masks, refused requests, loop control, resets, echo
// in both clock modes
// assumes: qbs_ctl drives the link inputs, qbs_chk is bound to the device
`timescale 1ns/100ps
`default_nettype none
module quad_rate_burst4_sram_port_bench
    import qbs_pkg::*;
;
    logic mclk = 1'b0, link_clk = 1'b0, nrst = 1'b0, loop_off_n = 1'b1;
    logic rs_n, ws_n, ml_n, mh_n, oc, ocn, oe_n, eck, eck_n, dll, scm, idle;
    qbs_sa_t   sa;
    qbs_data_t wd, rdo;
    qbs_data_t obs_d [1024];
    logic      obs_z [1024];
    logic      obs_e [1024];
    logic      obs_c [1024];
    logic [7:0] em [int];    // expected array contents by word address
    int mismatches = 0, checks_done = 0;
    always #50 mclk = ~mclk;
    always #15 link_clk = ~link_clk;
    qbs_ctl i_ctl (.link_clk(link_clk), .nrst(nrst), .read_sel_n(rs_n),
        .write_sel_n(ws_n), .shared_address(sa), .write_data_in(wd),
        .nibble_mask_low_n(ml_n), .nibble_mask_high_n(mh_n),
        .out_clk_c(oc), .out_clk_cn(ocn));
    qbs_sram i_dut (.mclk(mclk), .nrst(nrst), .link_clk(link_clk),
        .read_sel_n(rs_n), .write_sel_n(ws_n), .shared_address(sa),
        .write_data_in(wd), .nibble_mask_low_n(ml_n),
        .nibble_mask_high_n(mh_n), .out_clk_c(oc), .out_clk_cn(ocn),
        .loop_off_n(loop_off_n), .read_data_out(rdo), .read_data_oe_n(oe_n),
        .echo_clock_out(eck), .echo_clock_out_n(eck_n), .dll_enabled(dll),
        .single_clock_mode(scm), .read_port_idle(idle));
    // record the read pins as seen at each numbered link edge
    always @(posedge link_clk)
        if (i_ctl.nxt >= 0) begin
            obs_d[i_ctl.nxt] = rdo;
            obs_z[i_ctl.nxt] = oe_n;
            obs_e[i_ctl.nxt] = eck;
            obs_c[i_ctl.nxt] = oc;
        end
    task automatic check(input logic [8:0] seen, input logic [8:0] want);
        checks_done++;
        if (seen !== want) begin
            mismatches++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic [8:0] obs(input int n);
        return {obs_z[n], obs_z[n] ? 8'h00 : obs_d[n]};
    endfunction
    task automatic upto(input int n);
        while (i_ctl.nxt <= n) @(negedge link_clk);
    endtask
    task automatic sched_rd(input int e, input qbs_sa_t a);
        i_ctl.rd[e] = 1'b1;
        i_ctl.ad[e] = a;
    endtask
    // plan a write and fold its masked beats into the expected array
    task automatic sched_wr(input int e, input qbs_sa_t a,
        input logic [31:0] d, input logic [7:0] m);
        int key;
        logic [7:0] w;
        i_ctl.wr[e] = 1'b1;
        i_ctl.ad[e] = a;
        for (int k = 0; k < 4; k++) begin
            key = int'({a, k[1:0]});
            w = em.exists(key) ? em[key] : 8'hxx;
            w[3:0] = m[2*k] ? w[3:0] : d[8*k +: 4];
            w[7:4] = m[2*k+1] ? w[7:4] : d[8*k+4 +: 4];
            em[key] = w;
            i_ctl.bt[e+2+k] = 1'b1;
            i_ctl.wd[e+2+k] = d[8*k +: 8];
            i_ctl.wm[e+2+k] = m[2*k +: 2];
        end
    endtask
    task automatic chk_rd(input int e, input qbs_sa_t a, input bit last);
        upto(e + 9);
        for (int k = 0; k < 4; k++)
            check(obs(e + 4 + k), {1'b0, em[int'({a, k[1:0]})]});
        if (last) check(obs(e + 8), 9'h100);
    endtask
    task automatic t_reset(input logic dual);
        @(negedge mclk) nrst = 1'b0;
        repeat (4) @(negedge mclk);
        check({oe_n, idle, dll, eck, eck_n}, 5'h19);
        nrst = 1'b1;
        repeat (4) @(negedge mclk);
        check({scm, idle, dll, oe_n}, {~dual, 3'h7});
        $display("test reset done");
    endtask
    task automatic t_stream();
        int e;
        e = (i_ctl.nxt + 4) & ~1;
        sched_wr(e, 20'h00030, 32'h44332211, 8'h00);
        sched_wr(e + 4, 20'hfffff, 32'hddccbbaa, 8'h00);
        sched_rd(e + 8, 20'h00030);
        sched_rd(e + 12, 20'hfffff);
        chk_rd(e + 8, 20'h00030, 1'b0);
        chk_rd(e + 12, 20'hfffff, 1'b1);
        $display("test stream done");
    endtask
    task automatic t_mask();
        int e;
        e = (i_ctl.nxt + 4) & ~1;
        sched_wr(e, 20'h00abc, 32'hbbaa9988, 8'h00);
        sched_wr(e + 4, 20'h00abc, 32'h11223344, 8'he4);
        sched_rd(e + 10, 20'h00abc);
        chk_rd(e + 10, 20'h00abc, 1'b1);
        $display("test mask done");
    endtask
    // a second read and a second write both come too soon
    task automatic t_refuse();
        int e;
        e = (i_ctl.nxt + 4) & ~1;
        sched_wr(e, 20'h00077, 32'h5a6b7c8d, 8'h00);
        sched_rd(e + 2, 20'h00030);
        i_ctl.wr[e + 2] = 1'b1;
        sched_rd(e + 4, 20'h00abc);
        chk_rd(e + 2, 20'h00030, 1'b1);
        // chk_rd returns on the edge that reads plan e + 12; plan past it
        sched_rd(e + 14, 20'h00077);
        chk_rd(e + 14, 20'h00077, 1'b1);
        $display("test refuse done");
    endtask
    // echo follows the input edges, or the output clock three edges late
    task automatic t_echo(input logic dual);
        int n;
        n = i_ctl.nxt + 4;
        upto(n + 8);
        for (int k = 0; k < 4; k++)
            check(obs_e[n + k], dual ? obs_c[n + k - 3] : 1'(n + k));
        $display("test echo done");
    endtask
    task automatic t_dll();
        @(negedge mclk) loop_off_n = 1'b0;
        repeat (4) @(negedge mclk);
        check(dll, 1'b0);
        loop_off_n = 1'b1;
        repeat (4) @(negedge mclk);
        check(dll, 1'b1);
        $display("test loop done");
    endtask
    initial begin
        t_reset(1'b0);
        t_stream();
        t_echo(1'b0);
        t_mask();
        t_refuse();
        t_dll();
        // second run with running output clocks: dual clock mode
        i_ctl.oc_run = 1'b1;
        t_reset(1'b1);
        t_echo(1'b1);
        t_stream();
        conclude();
    end
    // the run needs well under 30 us; give it ten times that
    initial begin
        #300000;
        mismatches++;
        $display("watchdog expired");
        conclude();
    end
endmodule
`default_nettype wire

// >>> hdl/qbs_pkg.sv
// qbs_pkg: shared widths, burst constants, reset values, types and the
// address helper for the burst-of-four dual-port memory block.
// assumes: imported by the top module, the storage module and the dv controller, checker and bench.

package qbs_pkg;

    // port and array geometry of the 8-bit organization
    localparam int unsigned QBS_DATA_W  = 8;
    localparam int unsigned QBS_SA_W    = 20;
    localparam int unsigned QBS_BEAT_W  = 2;
    localparam int unsigned QBS_WADDR_W = QBS_SA_W + QBS_BEAT_W;
    localparam int unsigned QBS_WORDS   = 4194304;
    localparam int unsigned QBS_NIB_W   = 4;

    // burst beat indices: four sequential beats, 2-bit linear order
    localparam logic [1:0] QBS_FIRST_BEAT = 2'h0;
    localparam logic [1:0] QBS_LAST_BEAT  = 2'h3;
    localparam logic [1:0] QBS_BEAT_STEP  = 2'h1;

    // link edges a two-flop pin sample needs before it can be trusted
    localparam logic [1:0] QBS_SYNC_SETTLE = 2'h2;
    localparam logic [1:0] QBS_SETTLE_STEP = 2'h1;

    // power-up values: no burst pending, outputs released
    localparam logic QBS_RST_PEND   = 1'b0;
    localparam logic QBS_RST_SINGLE = 1'b0;
    localparam logic QBS_RST_ECHO   = 1'b0;
    localparam logic QBS_RST_IDLE   = 1'b1;
    localparam logic QBS_RST_DLL    = 1'b0;

    // which input-clock edge the current link edge stands for
    typedef enum logic {
        QBS_PH_K,
        QBS_PH_KN
    } qbs_phase_t;

    // read data driver state
    typedef enum logic {
        QBS_OUT_HIZ,
        QBS_OUT_DRIVE
    } qbs_drive_t;

    typedef logic [QBS_DATA_W-1:0]  qbs_data_t;
    typedef logic [QBS_SA_W-1:0]    qbs_sa_t;
    typedef logic [QBS_WADDR_W-1:0] qbs_waddr_t;

    // word address of one beat inside the four-word group of a burst
    function automatic qbs_waddr_t qbs_word_addr(
        input qbs_sa_t    base,
        input logic [1:0] beat
    );
        return {base, beat};
    endfunction

endpackage

// >>> hdl/qbs_sram.sv
// qbs_sram: burst-of-four memory device with separate read and write
// ports, double data rate on each, echo clocks and a status side.
// assumes: link_clk rises once per input-clock edge, the first edge after
// reset release standing for the true input clock, then alternating; all
// link pins except the output-clock pair are synchronous to link_clk.

`timescale 1ns/100ps
`default_nettype none

module qbs_sram
    import qbs_pkg::*;
(
    input  wire logic      mclk,
    input  wire logic      nrst,
    input  wire logic      link_clk,
    input  wire logic      read_sel_n,
    input  wire logic      write_sel_n,
    input  wire qbs_sa_t   shared_address,
    input  wire qbs_data_t write_data_in,
    input  wire logic      nibble_mask_low_n,
    input  wire logic      nibble_mask_high_n,
    input  wire logic      out_clk_c,
    input  wire logic      out_clk_cn,
    input  wire logic      loop_off_n,
    output var  qbs_data_t read_data_out,
    output var  logic      read_data_oe_n,
    output var  logic      echo_clock_out,
    output var  logic      echo_clock_out_n,
    output var  logic      dll_enabled,
    output var  logic      single_clock_mode,
    output var  logic      read_port_idle
);

    // ---------------------------------------------------------------
    // link-side state: command capture, burst counters, echo, mode
    // ---------------------------------------------------------------
    typedef struct packed {
        qbs_phase_t ph;          // edge that the next link edge stands for
        logic       rd_pend;     // read taken, launch due at next true edge
        qbs_sa_t    rd_cmd_addr;
        logic       out_act;     // read burst streaming out of the array
        logic [1:0] out_beat;
        qbs_sa_t    out_addr;
        qbs_drive_t drive;
        logic       wr_pend;     // write taken, data due from next true edge
        qbs_sa_t    wr_cmd_addr;
        logic       wr_act;      // write burst still taking beats
        logic [1:0] wr_beat;
        qbs_sa_t    wr_addr;
        logic       c_s1;
        logic       c_s2;
        logic       cn_s1;
        logic       cn_s2;
        logic [1:0] settle;
        logic       mode_cap;
        logic       single;
        logic       echo;
        logic       echo_n;
        logic       rd_idle;
    } qbs_link_t;

    // ---------------------------------------------------------------
    // core-side state: status brought over from the link and the pins
    // ---------------------------------------------------------------
    typedef struct packed {
        logic loff_s1;
        logic loff_s2;
        logic idle_s1;
        logic idle_s2;
        logic single_s1;
        logic single_s2;
    } qbs_core_t;

    qbs_link_t lnk_q;
    qbs_link_t lnk_d;
    qbs_core_t core_q;
    qbs_core_t core_d;

    logic       lrst_s1_q;
    logic       lrst_n_q;
    logic       is_k;
    logic       rd_take;
    logic       rd_launch;
    logic       wr_take;
    logic       wr_start;
    logic       st_rd_en;
    qbs_waddr_t st_rd_addr;
    logic       st_wr_en;
    qbs_waddr_t st_wr_addr;

    // link reset: asserted at once, released on link_clk so that the
    // first released edge is the same for every link register;
    // nrst alone would let them leave reset on different link edges
    always_ff @(posedge link_clk or negedge nrst) begin
        if (!nrst) begin
            lrst_s1_q <= 1'b0;
            lrst_n_q  <= 1'b0;
        end else begin
            lrst_s1_q <= 1'b1;
            lrst_n_q  <= lrst_s1_q;
        end
    end

    // request decode; only true edges carry commands, so selects seen
    // on complement edges are never looked at
    always_comb begin
        is_k      = (lnk_q.ph == QBS_PH_K);
        // the pending flag blocks the next true edge, so a second read
        // there can neither interrupt nor double the running burst
        rd_take   = is_k && !read_sel_n && !lnk_q.rd_pend;
        rd_launch = is_k && lnk_q.rd_pend;
        // read wins a shared true edge; an ignored read leaves it to write
        wr_take   = is_k && !write_sel_n && !lnk_q.wr_pend
                    && !rd_take;
        wr_start  = is_k && lnk_q.wr_pend;
    end

    // link next-state
    always_comb begin
        lnk_d = lnk_q;

        // edges alternate true and complement without pause
        lnk_d.ph = is_k ? QBS_PH_KN : QBS_PH_K;

        // command stage: pending flags live for one input cycle
        if (is_k) begin
            lnk_d.rd_pend = rd_take;
            lnk_d.wr_pend = wr_take;
        end
        if (rd_take) begin
            lnk_d.rd_cmd_addr = shared_address;
        end
        if (wr_take) begin
            lnk_d.wr_cmd_addr = shared_address;
        end

        // read stream: four beats, the next burst may load on the last
        if (lnk_q.out_act) begin
            lnk_d.out_beat = 2'(lnk_q.out_beat + QBS_BEAT_STEP);
            if (lnk_q.out_beat == QBS_LAST_BEAT) begin
                lnk_d.out_act = 1'b0;
            end
        end
        if (rd_launch) begin
            // command address copied so a new read may be taken meanwhile
            lnk_d.out_act  = 1'b1;
            lnk_d.out_beat = QBS_FIRST_BEAT;
            lnk_d.out_addr = lnk_q.rd_cmd_addr;
        end

        // drivers follow the stream one edge late, as the data does
        lnk_d.drive = lnk_q.out_act ? QBS_OUT_DRIVE : QBS_OUT_HIZ;

        // write stream: first beat on the start edge, three more follow
        if (lnk_q.wr_act) begin
            lnk_d.wr_beat = 2'(lnk_q.wr_beat + QBS_BEAT_STEP);
            if (lnk_q.wr_beat == QBS_LAST_BEAT) begin
                lnk_d.wr_act = 1'b0;
            end
        end
        if (wr_start) begin
            // beat 0 goes in on the start edge straight from the command
            // address, so the running counter resumes at beat 1
            lnk_d.wr_act  = 1'b1;
            lnk_d.wr_beat = 2'(QBS_FIRST_BEAT + QBS_BEAT_STEP);
            lnk_d.wr_addr = lnk_q.wr_cmd_addr;
        end

        // output-clock pins are free-running or held high, and unrelated to link_clk
        lnk_d.c_s1  = out_clk_c;
        lnk_d.c_s2  = lnk_q.c_s1;
        lnk_d.cn_s1 = out_clk_cn;
        lnk_d.cn_s2 = lnk_q.cn_s1;

        // mode is caught once after the samplers settle and then frozen;
        // switching later would tear the echo phase mid-burst
        if (!lnk_q.mode_cap) begin
            if (lnk_q.settle == QBS_SYNC_SETTLE) begin
                lnk_d.single   = lnk_q.c_s2 && lnk_q.cn_s2;
                lnk_d.mode_cap = 1'b1;
            end else begin
                lnk_d.settle = 2'(lnk_q.settle + QBS_SETTLE_STEP);
            end
        end

        // echo pair: follows the input clocks in single mode, else the
        // sampled output clock; never gated by read activity
        lnk_d.echo   = lnk_q.single ? is_k : lnk_q.c_s2;
        lnk_d.echo_n = !lnk_d.echo;

        // read port quiet: nothing pending, streaming or driven
        lnk_d.rd_idle = !lnk_d.rd_pend && !lnk_d.out_act
                        && (lnk_d.drive == QBS_OUT_HIZ);
    end

    // link registers; power-up leaves both ports idle and released
    always_ff @(posedge link_clk or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            lnk_q          <= '0;
            lnk_q.ph       <= QBS_PH_K;
            lnk_q.rd_pend  <= QBS_RST_PEND;
            lnk_q.wr_pend  <= QBS_RST_PEND;
            lnk_q.drive    <= QBS_OUT_HIZ;
            lnk_q.single   <= QBS_RST_SINGLE;
            lnk_q.echo     <= QBS_RST_ECHO;
            lnk_q.echo_n   <= !QBS_RST_ECHO;
            lnk_q.rd_idle  <= QBS_RST_IDLE;
        end else begin
            lnk_q <= lnk_d;
        end
    end

    // array strobes: read one edge before the word leaves the pins;
    // a read and a write of one word on the same edge give the old word
    always_comb begin
        st_rd_en   = lnk_q.out_act;
        st_rd_addr = qbs_word_addr(lnk_q.out_addr, lnk_q.out_beat);
        // masks and data are taken from the pins on every write beat
        st_wr_en   = wr_start || lnk_q.wr_act;
        st_wr_addr = wr_start
                     ? qbs_word_addr(lnk_q.wr_cmd_addr, QBS_FIRST_BEAT)
                     : qbs_word_addr(lnk_q.wr_addr, lnk_q.wr_beat);
    end

    // separate read and write ports into the array
    qbs_store u_store (
        .clk            (link_clk),
        .rst_n          (lrst_n_q),
        .rd_en          (st_rd_en),
        .rd_addr        (st_rd_addr),
        .rd_data_q      (read_data_out),
        .wr_en          (st_wr_en),
        .wr_addr        (st_wr_addr),
        .wr_data        (write_data_in),
        .wr_mask_low_n  (nibble_mask_low_n),
        .wr_mask_high_n (nibble_mask_high_n)
    );

    // core next-state: every level from outside passes two flops;
    // idle and mode are single-bit levels, so two flops per bit suffice
    // and no multi-bit word ever crosses from the link side
    always_comb begin
        core_d           = core_q;
        core_d.loff_s1   = loop_off_n;
        core_d.loff_s2   = core_q.loff_s1;
        core_d.idle_s1   = lnk_q.rd_idle;
        core_d.idle_s2   = core_q.idle_s1;
        core_d.single_s1 = lnk_q.single;
        core_d.single_s2 = core_q.single_s1;
    end

    // core registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            core_q           <= '0;
            core_q.loff_s1   <= QBS_RST_DLL;
            core_q.loff_s2   <= QBS_RST_DLL;
            core_q.idle_s1   <= QBS_RST_IDLE;
            core_q.idle_s2   <= QBS_RST_IDLE;
            core_q.single_s1 <= QBS_RST_SINGLE;
            core_q.single_s2 <= QBS_RST_SINGLE;
        end else begin
            core_q <= core_d;
        end
    end

    // pin outputs; drive enable is low while the data pins are driven
    // all of them come straight from flops, so no decode glitch escapes
    assign read_data_oe_n    = (lnk_q.drive != QBS_OUT_DRIVE);
    assign echo_clock_out    = lnk_q.echo;
    assign echo_clock_out_n  = lnk_q.echo_n;
    assign dll_enabled       = core_q.loff_s2;
    assign single_clock_mode = core_q.single_s2;
    assign read_port_idle    = core_q.idle_s2;

endmodule

`default_nettype wire

// >>> hdl/qbs_store.sv
// qbs_store: the word array with a registered read port and a nibble
// masked write port, both on the link clock.
// assumes: read and write strobes come from logic on the same clock.

`timescale 1ns/100ps
`default_nettype none

module qbs_store
    import qbs_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       rd_en,
    input  wire qbs_waddr_t rd_addr,
    output var  qbs_data_t  rd_data_q,
    input  wire logic       wr_en,
    input  wire qbs_waddr_t wr_addr,
    input  wire qbs_data_t  wr_data,
    input  wire logic       wr_mask_low_n,
    input  wire logic       wr_mask_high_n
);

    // storage has no reset; contents are undefined until written
    qbs_data_t mem [0:QBS_WORDS-1];

    // independent write port, each nibble gated by its own mask
    always_ff @(posedge clk) begin
        if (wr_en) begin
            if (!wr_mask_low_n) begin
                mem[wr_addr][QBS_NIB_W-1:0] <= wr_data[QBS_NIB_W-1:0];
            end
            if (!wr_mask_high_n) begin
                mem[wr_addr][QBS_DATA_W-1:QBS_NIB_W] <=
                    wr_data[QBS_DATA_W-1:QBS_NIB_W];
            end
        end
    end

    // read port runs alongside writes; same-word collision returns old data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= '0;
        end else if (rd_en) begin
            rd_data_q <= mem[rd_addr];
        end
    end

endmodule

`default_nettype wire
